// *** aesce_defines.svh ***
`ifndef AESCE_DEFINES_SVH
`define AESCE_DEFINES_SVH
// Register indices; byte address is four times the index
`define AESCE_IDX_CTRL     3'h0
`define AESCE_IDX_STATUS   3'h1
`define AESCE_IDX_STATE    3'h2
`define AESCE_IDX_KEY      3'h3
`define AESCE_IDX_INTCTRL  3'h4
`define AESCE_IDX_LAST     6'h04
// Control fields
`define AESCE_CTRL_START   7
`define AESCE_CTRL_AUTO    6
`define AESCE_CTRL_SRST    5
`define AESCE_CTRL_DIR     4
`define AESCE_CTRL_XOR     2
// Status fields
`define AESCE_STAT_ERR     7
`define AESCE_STAT_RDY     0
// Sizes and timing
`define AESCE_BLK_BITS     128
`define AESCE_PTR_BITS     4
`define AESCE_CNT_BITS     9
`define AESCE_RUN_CYCLES   9'd375
`define AESCE_ROUNDS       9'd10
`define AESCE_CNT_ONE      9'd1
`define AESCE_PTR_ONE      4'h1
`define AESCE_PTR_ZERO     4'h0
`endif

// *** aesce_pkg.sv ***
package aesce_pkg;
`include "aesce_defines.svh"
  typedef enum logic {AESCE_IDLE, AESCE_BUSY} aesce_phase_t;
  typedef struct packed {
    aesce_phase_t                 phase;
    logic                         auto_start;
    logic                         direction_select;
    logic                         xor_load;
    logic                         misuse;
    logic                         state_ready_flag;
    logic [1:0]                   intlvl;
    logic [`AESCE_PTR_BITS-1:0]   srp;
    logic [`AESCE_PTR_BITS-1:0]   swp;
    logic [`AESCE_PTR_BITS-1:0]   krp;
    logic [`AESCE_PTR_BITS-1:0]   kwp;
    logic [`AESCE_PTR_BITS-1:0]   acc;
    logic [`AESCE_CNT_BITS-1:0]   cnt;
    logic [`AESCE_BLK_BITS-1:0]   smem;
    logic [`AESCE_BLK_BITS-1:0]   kmem;
    logic                         pready;
    logic                         pslverr;
    logic [31:0]                  prdata;
    logic                         irq;
    logic                         dma;
  } aesce_state_t;
endpackage

// *** aesce_engine.sv ***
`timescale 1ns/1ps
`include "aesce_defines.svh"
module aesce_engine
  import aesce_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RESET_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  output logic             IRQ_O,
  output logic             DMA_TRIG_O
);

  // ----------------------------------------------------------------
  // Galois field and cipher helpers (byte i sits at bits 8i+7..8i)
  // ----------------------------------------------------------------
  function automatic logic [7:0] xt(input logic [7:0] a);
    xt = {a[6:0], 1'b0} ^ (a[7] ? 8'h1B : 8'h00);
  endfunction

  function automatic logic [7:0] gmul(input logic [7:0] a,
                                      input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ x;
      x = xt(x);
    end
    gmul = p;
  endfunction

  // Field inverse as x^254; costly in area but needs no lookup table
  function automatic logic [7:0] ginv(input logic [7:0] a);
    logic [7:0] y;
    logic [7:0] s;
    y = 8'h01;
    s = a;
    for (int i = 0; i < 7; i++) begin
      s = gmul(s, s);
      y = gmul(y, s);
    end
    ginv = y;
  endfunction

  function automatic logic [7:0] rl(input logic [7:0] a, input int n);
    rl = (a << n) | (a >> (8 - n));
  endfunction

  function automatic logic [7:0] sb(input logic [7:0] a);
    logic [7:0] b;
    b = ginv(a);
    sb = b ^ rl(b, 1) ^ rl(b, 2) ^ rl(b, 3) ^ rl(b, 4) ^ 8'h63;
  endfunction

  function automatic logic [7:0] isb(input logic [7:0] a);
    isb = ginv(rl(a, 1) ^ rl(a, 3) ^ rl(a, 6) ^ 8'h05);
  endfunction

  function automatic logic [7:0] rcon(input logic [8:0] r);
    logic [7:0] c;
    c = 8'h01;
    for (int j = 1; j < 10; j++) begin
      if (9'(j) < r) c = xt(c);
    end
    rcon = c;
  endfunction

  function automatic logic [31:0] subw(input logic [31:0] w);
    subw = {sb(w[31:24]), sb(w[23:16]), sb(w[15:8]), sb(w[7:0])};
  endfunction

  // Words hold bytes little end first, so rotation moves byte 1 down
  function automatic logic [127:0] knext(input logic [127:0] k,
                                         input logic [7:0]   rc);
    logic [31:0] w0;
    logic [31:0] w1;
    logic [31:0] w2;
    logic [31:0] w3;
    w3 = k[127:96];
    w0 = k[31:0] ^ subw({w3[7:0], w3[31:8]}) ^ {24'h000000, rc};
    w1 = k[63:32] ^ w0;
    w2 = k[95:64] ^ w1;
    w3 = w3 ^ w2;
    knext = {w3, w2, w1, w0};
  endfunction

  function automatic logic [127:0] kprev(input logic [127:0] k,
                                         input logic [7:0]   rc);
    logic [31:0] w0;
    logic [31:0] w1;
    logic [31:0] w2;
    logic [31:0] w3;
    w3 = k[127:96] ^ k[95:64];
    w2 = k[95:64] ^ k[63:32];
    w1 = k[63:32] ^ k[31:0];
    w0 = k[31:0] ^ subw({w3[7:0], w3[31:8]}) ^ {24'h000000, rc};
    kprev = {w3, w2, w1, w0};
  endfunction

  function automatic logic [127:0] enc_rnd(input logic [127:0] s,
                                           input logic [127:0] k,
                                           input logic         last);
    logic [127:0] t;
    logic [7:0]   a0;
    logic [7:0]   a1;
    logic [7:0]   a2;
    logic [7:0]   a3;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        t[8*(4*c+r) +: 8] = sb(s[8*(4*((c+r)%4)+r) +: 8]);
      end
    end
    if (!last) begin
      for (int c = 0; c < 4; c++) begin
        a0 = t[32*c +: 8];
        a1 = t[32*c+8 +: 8];
        a2 = t[32*c+16 +: 8];
        a3 = t[32*c+24 +: 8];
        t[32*c +: 32] = {xt(a0) ^ a0 ^ a1 ^ a2 ^ xt(a3),
                         a0 ^ a1 ^ xt(a2) ^ xt(a3) ^ a3,
                         a0 ^ xt(a1) ^ xt(a2) ^ a2 ^ a3,
                         xt(a0) ^ xt(a1) ^ a1 ^ a2 ^ a3};
      end
    end
    enc_rnd = t ^ k;
  endfunction

  function automatic logic [127:0] dec_rnd(input logic [127:0] s,
                                           input logic [127:0] k,
                                           input logic         last);
    logic [127:0] t;
    logic [7:0]   a [4];
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        t[8*(4*c+r) +: 8] = isb(s[8*(4*((c+4-r)%4)+r) +: 8]);
      end
    end
    t = t ^ k;
    if (!last) begin
      for (int c = 0; c < 4; c++) begin
        for (int r = 0; r < 4; r++) a[r] = t[32*c+8*r +: 8];
        for (int r = 0; r < 4; r++) begin
          t[32*c+8*r +: 8] = gmul(a[r], 8'h0E) ^
                             gmul(a[(r+1)%4], 8'h0B) ^
                             gmul(a[(r+2)%4], 8'h0D) ^
                             gmul(a[(r+3)%4], 8'h09);
        end
      end
    end
    dec_rnd = t;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  aesce_state_t st;
  aesce_state_t next_st;

  logic       setup;
  logic       acc_go;
  logic       mapped;
  logic [2:0] idx;
  logic [7:0] wb;
  logic       launch;
  logic [3:0] acc_now;

  assign setup  = PSEL_I && !PENABLE_I;
  assign acc_go = PSEL_I && PENABLE_I && st.pready;
  assign mapped = PADDR_I[7:2] <= `AESCE_IDX_LAST;
  assign idx    = PADDR_I[4:2];
  assign wb     = PWDATA_I[7:0];

  always_comb begin
    next_st = st;
    launch  = 1'b0;
    acc_now = st.acc;
    next_st.dma = 1'b0;
    // APB: one wait-free access phase; read data is built in setup
    next_st.pready  = setup;
    next_st.pslverr = setup && !mapped;
    if (setup) begin
      next_st.prdata = 32'h00000000;
      if (mapped) begin
        unique case (idx)
          `AESCE_IDX_CTRL: begin
            next_st.prdata[`AESCE_CTRL_START] = st.phase == AESCE_BUSY;
            next_st.prdata[`AESCE_CTRL_AUTO]  = st.auto_start;
            next_st.prdata[`AESCE_CTRL_DIR]   = st.direction_select;
            next_st.prdata[`AESCE_CTRL_XOR]   = st.xor_load;
          end
          `AESCE_IDX_STATUS: begin
            next_st.prdata[`AESCE_STAT_ERR] = st.misuse;
            next_st.prdata[`AESCE_STAT_RDY] = st.state_ready_flag;
          end
          `AESCE_IDX_STATE:
            if (st.phase == AESCE_IDLE)
              next_st.prdata[7:0] = st.smem[{st.srp, 3'b000} +: 8];
          `AESCE_IDX_KEY:
            if (st.phase == AESCE_IDLE)
              next_st.prdata[7:0] = st.kmem[{st.krp, 3'b000} +: 8];
          `AESCE_IDX_INTCTRL: next_st.prdata[1:0] = st.intlvl;
          default: ;
        endcase
      end
    end
    // ----------------------------------------------------------------
    // Register side effects at the completing edge
    // ----------------------------------------------------------------
    if (acc_go && mapped) begin
      unique case (idx)
        `AESCE_IDX_CTRL: begin
          next_st.srp = `AESCE_PTR_ZERO;
          next_st.swp = `AESCE_PTR_ZERO;
          next_st.krp = `AESCE_PTR_ZERO;
          next_st.kwp = `AESCE_PTR_ZERO;
          if (st.phase == AESCE_BUSY) begin
            // Any control touch while busy, an abort included, is misuse
            next_st.misuse = 1'b1;
            next_st.phase  = AESCE_IDLE;
          end else if (PWRITE_I) begin
            next_st.auto_start       = wb[`AESCE_CTRL_AUTO];
            next_st.direction_select = wb[`AESCE_CTRL_DIR];
            next_st.xor_load         = wb[`AESCE_CTRL_XOR];
            launch = wb[`AESCE_CTRL_START];
          end
        end
        `AESCE_IDX_STATUS:
          if (PWRITE_I) begin
            if (wb[`AESCE_STAT_ERR]) next_st.misuse = 1'b0;
            if (wb[`AESCE_STAT_RDY])
              next_st.state_ready_flag = 1'b0;
          end
        `AESCE_IDX_STATE:
          if (st.phase == AESCE_IDLE) begin
            acc_now = st.acc + `AESCE_PTR_ONE;
            if (PWRITE_I) begin
              if (st.xor_load) begin
                next_st.smem[{st.swp, 3'b000} +: 8] =
                  st.smem[{st.swp, 3'b000} +: 8] ^ wb;
                next_st.srp = st.srp + `AESCE_PTR_ONE;
              end else begin
                next_st.smem[{st.swp, 3'b000} +: 8] = wb;
              end
              next_st.swp = st.swp + `AESCE_PTR_ONE;
              if (st.auto_start && &st.swp) launch = 1'b1;
            end else begin
              next_st.srp = st.srp + `AESCE_PTR_ONE;
              next_st.state_ready_flag = 1'b0;
            end
          end
        `AESCE_IDX_KEY:
          if (st.phase == AESCE_IDLE) begin
            acc_now = st.acc + `AESCE_PTR_ONE;
            if (PWRITE_I) begin
              next_st.kmem[{st.kwp, 3'b000} +: 8] = wb;
              next_st.kwp = st.kwp + `AESCE_PTR_ONE;
              if (st.xor_load)
                next_st.krp = st.krp + `AESCE_PTR_ONE;
            end else begin
              next_st.krp = st.krp + `AESCE_PTR_ONE;
            end
          end
        `AESCE_IDX_INTCTRL:
          if (PWRITE_I) next_st.intlvl = wb[1:0];
        default: ;
      endcase
      next_st.acc = acc_now;
    end
    if (launch) begin
      next_st.acc = `AESCE_PTR_ZERO;
      if (acc_now != `AESCE_PTR_ZERO) begin
        next_st.misuse = 1'b1;
      end else begin
        next_st.phase = AESCE_BUSY;
        next_st.cnt   = '0;
        next_st.state_ready_flag = 1'b0;
      end
    end
    // ----------------------------------------------------------------
    // Engine: key add, ten rounds in place, then wait out the slot
    // ----------------------------------------------------------------
    if (st.phase == AESCE_BUSY &&
        !(acc_go && mapped && idx == `AESCE_IDX_CTRL)) begin
      if (st.cnt == '0) begin
        next_st.smem = st.smem ^ st.kmem;
      end else if (st.cnt <= `AESCE_ROUNDS) begin
        if (!st.direction_select) begin
          next_st.kmem = knext(st.kmem, rcon(st.cnt));
          next_st.smem = enc_rnd(st.smem, next_st.kmem,
                                 st.cnt == `AESCE_ROUNDS);
        end else begin
          next_st.kmem = kprev(st.kmem, rcon(`AESCE_ROUNDS + `AESCE_CNT_ONE
                                             - st.cnt));
          next_st.smem = dec_rnd(st.smem, next_st.kmem,
                                 st.cnt == `AESCE_ROUNDS);
        end
      end
      next_st.cnt = st.cnt + `AESCE_CNT_ONE;
      if (st.cnt == `AESCE_RUN_CYCLES - `AESCE_CNT_ONE) begin
        next_st.phase = AESCE_IDLE;
        next_st.state_ready_flag = 1'b1;
        next_st.dma = 1'b1;
      end
    end
    next_st.irq = next_st.state_ready_flag && (next_st.intlvl != 2'b00);
    // Soft clear wins over everything else in the same access
    if (acc_go && mapped && PWRITE_I && idx == `AESCE_IDX_CTRL &&
        wb[`AESCE_CTRL_SRST] && st.phase == AESCE_IDLE) begin
      next_st = '0;
      next_st.phase = AESCE_IDLE;
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign PRDATA_O   = st.prdata;
  assign PREADY_O   = st.pready;
  assign PSLVERR_O  = st.pslverr;
  assign IRQ_O      = st.irq;
  assign DMA_TRIG_O = st.dma;

endmodule

// *** aesce_assertions.sv ***
`timescale 1ns/1ps
module aesce_assertions (
  input wire logic        CLK_I,
  input wire logic        RESET_I,
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic        IRQ_O,
  input wire logic        DMA_TRIG_O
);
  logic       take;
  logic       go;
  logic       int_wr;
  logic [5:0] idx;
  logic [9:0] since_go;
  assign idx    = PADDR_I[7:2];
  assign take   = PSEL_I && PENABLE_I && PREADY_O;
  assign int_wr = take && PWRITE_I && idx == 6'h04;
  assign go = take && PWRITE_I &&
              (idx == 6'h02 || (idx == 6'h00 && PWDATA_I[7]));
  // Saturates, so an old launch can never line up with a late trigger
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      since_go <= 10'h3FF;
    end else if (go) begin
      since_go <= 10'h000;
    end else if (since_go != 10'h3FF) begin
      since_go <= since_go + 10'h001;
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RESET_I);
  property p_answer; PSEL_I && !PENABLE_I |=> PREADY_O; endproperty
  a_answer: assert property (p_answer)
    else $error("setup cycle got no answer");
  property p_only;
    PREADY_O |-> PSEL_I && PENABLE_I && $past(PSEL_I) && !$past(PENABLE_I);
  endproperty
  a_only: assert property (p_only)
    else $error("answer outside first access cycle");
  property p_unmapped; PREADY_O |-> PSLVERR_O == (idx > 6'h04); endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("error response does not match address");
  property p_rdata;
    PREADY_O && !PWRITE_I |->
      PRDATA_O[31:8] == 24'h0 && (!PSLVERR_O || PRDATA_O == 32'h0);
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("read data wider than a byte");
  property p_go_375; DMA_TRIG_O |-> since_go == 10'h177; endproperty
  a_go_375: assert property (p_go_375)
    else $error("completion not 375 cycles after launch");
  property p_dma_one; DMA_TRIG_O |=> !DMA_TRIG_O; endproperty
  a_dma_one: assert property (p_dma_one)
    else $error("transfer trigger longer than one cycle");
  property p_irq_rise;
    $rose(IRQ_O) |-> DMA_TRIG_O || $past(int_wr);
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("interrupt rose without completion");
  property p_irq_clear;
    IRQ_O && take && !PWRITE_I && idx == 6'h02 |-> ##[1:2] !IRQ_O;
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("state read left interrupt standing");
  property p_ctrl_rsv;
    take && !PWRITE_I && idx == 6'h00 |->
      PRDATA_O[5] == 1'h0 && PRDATA_O[3] == 1'h0 && PRDATA_O[1:0] == 2'h0;
  endproperty
  a_ctrl_rsv: assert property (p_ctrl_rsv)
    else $error("control read shows clear or reserved bits");
  c_done: cover property (DMA_TRIG_O);
  c_irq: cover property ($rose(IRQ_O));
  c_err: cover property (PREADY_O && PSLVERR_O);
endmodule

bind aesce_engine aesce_assertions i_chk (
  .CLK_I(CLK_I), .RESET_I(RESET_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
  .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .IRQ_O(IRQ_O), .DMA_TRIG_O(DMA_TRIG_O)
);

// *** aesce_host.sv ***
`timescale 1ns/1ps
module aesce_host (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        req_i,
  input  wire logic        wr_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        pready_i,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pslverr_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic      [7:0]  paddr_o,
  output logic      [31:0] pwdata_o,
  output logic             done_o,
  output logic      [31:0] rdata_o,
  output logic             err_o
);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} <= '0;
      {done_o, rdata_o, err_o} <= '0;
    end else if (psel_o && penable_o && pready_i) begin
      {psel_o, penable_o, done_o} <= 3'h1;
      rdata_o <= prdata_i;
      err_o <= pslverr_i;
      // Released lines flip so nothing leans on a stale value
      pwrite_o <= ~pwrite_o;
      paddr_o <= ~paddr_o;
      pwdata_o <= ~pwdata_o;
    end else if (psel_o) begin
      penable_o <= 1'h1;
    end else if (req_i && !done_o) begin
      // One byte per transfer, held until the answer edge
      psel_o <= 1'h1;
      pwrite_o <= wr_i;
      paddr_o <= addr_i;
      pwdata_o <= wdata_i;
    end else begin
      done_o <= 1'h0;
    end
  end
endmodule

// *** aes128_block_crypto_engine_tb.sv ***
`timescale 1ns/1ps
`include "aesce_defines.svh"
module aes128_block_crypto_engine_tb;
  import aesce_pkg::*;
  localparam logic [127:0] KEY0 = 128'h000102030405060708090A0B0C0D0E0F;
  localparam logic [127:0] PT   = 128'h00112233445566778899AABBCCDDEEFF;
  localparam logic [127:0] CT   = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
  // Last round key of KEY0, expanded offline for the direction_select run
  localparam logic [127:0] RK10 = 128'h13111D7FE3944A17F307A78B4D2B30C5;
  localparam logic [127:0] XP   = PT ^ {32'hFFFFFFFF, 96'h0};
  localparam logic [31:0]  RUN  = 32'(`AESCE_RUN_CYCLES);
  localparam logic [2:0]   CTL  = `AESCE_IDX_CTRL;
  localparam logic [2:0]   STA  = `AESCE_IDX_STATUS;
  localparam logic [2:0]   STM  = `AESCE_IDX_STATE;
  localparam logic [2:0]   KYM  = `AESCE_IDX_KEY;
  localparam logic [2:0]   INT  = `AESCE_IDX_INTCTRL;
  logic        clk, rst, req, wr, done, err;
  logic        psel, penable, pwrite, pready, pslverr, irq, dma;
  logic [7:0]  paddr, addr;
  logic [31:0] pwdata, prdata, wdata, rdata;
  int          num_errors, check_count, n;

  aesce_engine i_dut (
    .CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .IRQ_O(irq), .DMA_TRIG_O(dma));
  aesce_host i_host (
    .clk_i(clk), .rst_i(rst), .req_i(req), .wr_i(wr), .addr_i(addr),
    .wdata_i(wdata), .pready_i(pready), .prdata_i(prdata),
    .pslverr_i(pslverr), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata),
    .done_o(done), .rdata_o(rdata), .err_o(err));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [2:0] idx,
                     input logic [7:0] d);
    int k;
    @(posedge clk);
    req <= 1'h1;
    wr <= w;
    addr <= {3'h0, idx, 2'h0};
    wdata <= {24'h0, d};
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (done !== 1'h1 && k < 40);
    if (k >= 40) num_errors++;
    @(posedge clk);
    req <= 1'h0;
  endtask
  task automatic rd(input logic [2:0] idx, input string what,
                    input logic [7:0] exp);
    apb(1'h0, idx, 8'h00);
    check(what, rdata, {24'h0, exp});
  endtask
  task automatic load(input logic [2:0] idx, input logic [127:0] b);
    for (int i = 0; i < 16; i++) begin
      apb(1'h1, idx, b[127-8*i -: 8]);
    end
  endtask
  task automatic dump(input logic [2:0] idx, input string what,
                      input logic [127:0] b);
    for (int i = 0; i < 16; i++) begin
      rd(idx, what, b[127-8*i -: 8]);
    end
  endtask
  task automatic wait_dma();
    n = 1;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (dma !== 1'h1 && n < 600);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    rd(CTL, "ctrl reset", 8'h00);
    rd(STA, "status reset", 8'h00);
    rd(INT, "intctrl reset", 8'h00);
    apb(1'h1, 3'h5, 8'hFF);
    check("unmapped write err", {31'h0, err}, 32'h1);
    rd(3'h7, "unmapped read", 8'h00);
    check("unmapped read err", {31'h0, err}, 32'h1);
    $display("t_regs done");
  endtask
  task automatic t_encrypt();
    apb(1'h1, INT, 8'h01);
    apb(1'h1, CTL, 8'h00);
    load(KYM, KEY0);
    load(STM, PT);
    apb(1'h1, CTL, 8'h80);
    wait_dma();
    check("encrypt cycles", n, RUN);
    check("irq on done", {31'h0, irq}, 32'h1);
    @(posedge clk);
    #1;
    check("trigger end", {31'h0, dma}, 32'h0);
    rd(STA, "ready flag", 8'h01);
    rd(CTL, "run bit clear", 8'h00);
    dump(STM, "ciphertext", CT);
    check("irq after read", {31'h0, irq}, 32'h0);
    dump(KYM, "last subkey", RK10);
    $display("t_encrypt done");
  endtask
  task automatic t_direction_select();
    apb(1'h1, INT, 8'h00);
    apb(1'h1, CTL, 8'h10);
    load(KYM, RK10);
    load(STM, CT);
    apb(1'h1, CTL, 8'h90);
    wait_dma();
    check("direction_select cycles", n, RUN);
    check("irq masked", {31'h0, irq}, 32'h0);
    rd(CTL, "direction kept", 8'h10);
    dump(STM, "plaintext", PT);
    dump(KYM, "original key", KEY0);
    $display("t_direction_select done");
  endtask
  task automatic t_xor();
    apb(1'h1, CTL, 8'h04);
    for (int i = 0; i < 4; i++) apb(1'h1, STM, 8'hFF);
    rd(STM, "xor read pointer", PT[95:88]);
    apb(1'h1, CTL, 8'h00);
    for (int i = 0; i < 17; i++) begin
      rd(STM, "xor state", XP[127-8*(i%16) -: 8]);
    end
    $display("t_xor done");
  endtask
  task automatic t_misuse();
    apb(1'h1, CTL, 8'h00);
    for (int i = 0; i < 3; i++) apb(1'h1, KYM, 8'hA5);
    apb(1'h1, CTL, 8'h80);
    rd(STA, "count misuse", 8'h80);
    rd(CTL, "no run", 8'h00);
    apb(1'h1, STA, 8'h80);
    rd(STA, "misuse cleared", 8'h00);
    apb(1'h1, CTL, 8'h80);
    rd(KYM, "busy key read", 8'h00);
    apb(1'h1, CTL, 8'h00);
    rd(STA, "busy ctrl misuse", 8'h80);
    wait_dma();
    check("abort no trigger", n, 32'h258);
    $display("t_misuse done");
  endtask
  task automatic t_auto();
    apb(1'h1, INT, 8'h03);
    apb(1'h1, CTL, 8'h20);
    rd(CTL, "soft clear ctrl", 8'h00);
    rd(STA, "soft clear status", 8'h00);
    rd(INT, "soft clear intctrl", 8'h00);
    apb(1'h1, CTL, 8'h40);
    load(KYM, KEY0);
    load(STM, PT);
    wait_dma();
    check("auto cycles", n, RUN);
    rd(STA, "auto ready", 8'h01);
    apb(1'h1, STA, 8'h01);
    rd(STA, "ready write one clear", 8'h00);
    dump(STM, "auto ciphertext", CT);
    $display("t_auto done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // Whole run is a few thousand cycles; this leaves wide margin
  initial begin
    #500000;
    num_errors++;
    finish_test();
  end
  initial begin
    {rst, req, wr, addr, wdata} = {1'h1, 42'h0};
    num_errors = 0;
    check_count = 0;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    t_regs();
    t_encrypt();
    t_direction_select();
    t_xor();
    t_misuse();
    t_auto();
    finish_test();
  end
endmodule
